// *** pin_function_select.sv ***
// module: 16-pin port function select with apb register access
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pin_function_select
	import pin_mux_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// package pins
	input wire logic [15:0] pin_in,
	output logic [15:0] pin_out,
	output logic [15:0] pin_oe,
	// general-purpose port logic
	input wire logic [15:0] port_out,
	output logic [15:0] port_in,
	// timer channel 2 capture/compare a
	input wire logic timer_ch2_a_out,
	output logic timer_ch2_a_in,
	output logic timer_ch2_a_capture
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [15:0] mode_15_12;
		logic [15:0] mode_11_8;
		logic [15:0] mode_7_4;
		logic [15:0] mode_3_0;
		logic [15:0] direction;
		logic [31:0] rdata;
		logic ready;
		logic slverr;
		logic [15:0] pin_out;
		logic [15:0] pin_oe;
		logic [15:0] port_in;
		logic timer_in;
		logic timer_in_prev;
		logic capture;
	} pmux_state_t;

	pmux_state_t state_q;
	pmux_state_t state_d;
	logic [15:0] pin_sync_lvl;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// 3-bit mode of pin n; two-bit fields (pins 13 and 0) are zero-extended
	function automatic logic [2:0] pin_mode(input logic [63:0] regs, input int n);
		logic [15:0] r;
		r = regs[(n/4)*16 +: 16];
		return r[(n%4)*4 +: 3];
	endfunction

	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	// pin levels are asynchronous to clk
	pin_sync #(
		.WIDTH(NUM_PINS)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.async_in(pin_in),
		.sync_out(pin_sync_lvl)
	);

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		logic [63:0] modes;
		logic [15:0] wd;
		logic access;
		logic known;
		modes = '0;
		wd = '0;
		access = 1'b0;
		known = 1'b0;
		state_d = state_q;

		// one-wait slave: ready goes high in the cycle after the first access cycle
		access = psel && penable && !state_q.ready;
		state_d.ready = access;
		state_d.slverr = 1'b0;
		wd = pwdata[15:0];
		known = addr_hit(paddr, OFF_MODE_3_0) || addr_hit(paddr, OFF_MODE_7_4)
			|| addr_hit(paddr, OFF_MODE_11_8) || addr_hit(paddr, OFF_MODE_15_12)
			|| addr_hit(paddr, OFF_DIRECTION) || addr_hit(paddr, OFF_PIN_LEVEL);

		if (access) begin
			state_d.slverr = !known;
			if (pwrite) begin
				if (addr_hit(paddr, OFF_MODE_15_12)) begin
					state_d.mode_15_12 = wd & MASK_MODE_15_12;
				end
				if (addr_hit(paddr, OFF_MODE_11_8)) begin
					state_d.mode_11_8 = wd & MASK_MODE_11_8;
				end
				if (addr_hit(paddr, OFF_MODE_7_4)) begin
					state_d.mode_7_4 = wd & MASK_MODE_7_4;
				end
				if (addr_hit(paddr, OFF_MODE_3_0)) begin
					state_d.mode_3_0 = wd & MASK_MODE_3_0;
				end
				if (addr_hit(paddr, OFF_DIRECTION)) begin
					state_d.direction = wd & MASK_DIRECTION;
				end
				state_d.rdata = '0;
			end else begin
				case (1'b1)
					addr_hit(paddr, OFF_MODE_15_12): state_d.rdata = {16'h0000, state_q.mode_15_12};
					addr_hit(paddr, OFF_MODE_11_8): state_d.rdata = {16'h0000, state_q.mode_11_8};
					addr_hit(paddr, OFF_MODE_7_4): state_d.rdata = {16'h0000, state_q.mode_7_4};
					addr_hit(paddr, OFF_MODE_3_0): state_d.rdata = {16'h0000, state_q.mode_3_0};
					addr_hit(paddr, OFF_DIRECTION): state_d.rdata = {16'h0000, state_q.direction};
					addr_hit(paddr, OFF_PIN_LEVEL): state_d.rdata = {16'h0000, pin_sync_lvl};
					default: state_d.rdata = '0;
				endcase
			end
		end

		// ---------------------------------------------------------------
		// pin routing
		// ---------------------------------------------------------------
		modes = {state_q.mode_15_12, state_q.mode_11_8, state_q.mode_7_4, state_q.mode_3_0};
		state_d.timer_in = 1'b0;
		for (int n = 0; n < NUM_PINS; n++) begin
			state_d.pin_oe[n] = state_q.direction[n];
			if (pin_mode(modes, n) == MODE_PORT) begin
				state_d.pin_out[n] = port_out[n];
				state_d.port_in[n] = pin_sync_lvl[n];
			end else if (n == PIN6 && pin_mode(modes, n) == MODE_TIMER_CH2_A) begin
				state_d.pin_out[n] = timer_ch2_a_out;
				state_d.port_in[n] = 1'b0;
				state_d.timer_in = !state_q.direction[n] && pin_sync_lvl[n];
			end else begin
				// unlisted modes have no peripheral here: pin parks low
				state_d.pin_out[n] = 1'b0;
				state_d.port_in[n] = 1'b0;
			end
		end

		state_d.timer_in_prev = state_q.timer_in;
		state_d.capture = state_q.timer_in && !state_q.timer_in_prev;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= '0;
			state_q.mode_15_12 <= RST_MODE;
			state_q.mode_11_8 <= RST_MODE;
			state_q.mode_7_4 <= RST_MODE;
			state_q.mode_3_0 <= RST_MODE;
			state_q.direction <= RST_DIRECTION;
		end else begin
			state_q <= state_d;
		end
	end

	// ---------------------------------------------------------------
	// outputs, all from flops
	// ---------------------------------------------------------------
	assign prdata = state_q.rdata;
	assign pready = state_q.ready;
	assign pslverr = state_q.slverr;
	assign pin_out = state_q.pin_out;
	assign pin_oe = state_q.pin_oe;
	assign port_in = state_q.port_in;
	assign timer_ch2_a_in = state_q.timer_in;
	assign timer_ch2_a_capture = state_q.capture;
endmodule
`default_nettype wire

// *** pin_mux_pkg.sv ***
// package: register map, field layout and reset values of the port pin function select block
package pin_mux_pkg;

	// ---------------------------------------------------------------
	// register byte offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] OFF_MODE_3_0 = 8'h00;
	localparam logic [7:0] OFF_MODE_7_4 = 8'h04;
	localparam logic [7:0] OFF_MODE_11_8 = 8'h08;
	localparam logic [7:0] OFF_MODE_15_12 = 8'h0C;
	localparam logic [7:0] OFF_DIRECTION = 8'h10;
	localparam logic [7:0] OFF_PIN_LEVEL = 8'h14;

	// ---------------------------------------------------------------
	// writable bit masks; reserved bits are zero here
	// ---------------------------------------------------------------
	localparam logic [15:0] MASK_MODE_15_12 = 16'h7737;
	localparam logic [15:0] MASK_MODE_11_8 = 16'h7777;
	localparam logic [15:0] MASK_MODE_7_4 = 16'h7777;
	localparam logic [15:0] MASK_MODE_3_0 = 16'h7773;
	localparam logic [15:0] MASK_DIRECTION = 16'hFFFF;

	// ---------------------------------------------------------------
	// values after reset
	// ---------------------------------------------------------------
	localparam logic [15:0] RST_MODE = 16'h0000;
	localparam logic [15:0] RST_DIRECTION = 16'h0000;

	// ---------------------------------------------------------------
	// field positions and mode codes
	// ---------------------------------------------------------------
	localparam int PIN6_MODE_LSB = 8;
	localparam int PIN6 = 6;
	localparam logic [2:0] MODE_PORT = 3'h0;
	localparam logic [2:0] MODE_TIMER_CH2_A = 3'h1;
	localparam int NUM_PINS = 16;
	localparam int SYNC_STAGES = 2;

endpackage

// *** pin_sync.sv ***
// module: two-flop synchroniser for the pin input levels
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_state_t;

	sync_state_t state_q;
	sync_state_t state_d;

	always_comb begin
		state_d.meta = async_in;
		// first stage is read only by the second stage
		state_d.stable = state_q.meta;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign sync_out = state_q.stable;
endmodule
`default_nettype wire

// *** pin_function_select_assertions.sv ***
// checker: bus and pin routing assertions for the pin function select block
`timescale 1ns/1ps
`default_nettype none
module pin_function_select_assertions
	import pin_mux_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [15:0] pin_oe,
	input wire logic [15:0] port_in,
	input wire logic timer_ch2_a_in,
	input wire logic timer_ch2_a_capture
);
	// ---------------------------------------------------------------
	// properties
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence s_first_access;
		psel && penable && !pready;
	endsequence
	sequence s_dir_write;
		pready && psel && pwrite && paddr == OFF_DIRECTION;
	endsequence
	a_ready_wait: assert property (s_first_access |=> pready)
		else $error("no ready one cycle after access");
	a_dir_output: assert property (s_dir_write |=> pin_oe == $past(pwdata[15:0]))
		else $error("pin enable differs from written direction");
	a_unmapped_err: assert property (pready && paddr > OFF_PIN_LEVEL |-> pslverr && prdata == 0)
		else $error("unmapped access not refused");
	a_top_rsv: assert property (pready && !pwrite && paddr == OFF_MODE_15_12
		|-> (prdata & ~{16'h0, MASK_MODE_15_12}) == 0)
		else $error("reserved bits of top mode word not zero");
	a_low_rsv: assert property (pready && !pwrite && paddr == OFF_MODE_3_0
		|-> (prdata & ~{16'h0, MASK_MODE_3_0}) == 0)
		else $error("reserved bits of low mode word not zero");
	a_capture_rise: assert property ($rose(timer_ch2_a_in) |=> timer_ch2_a_capture)
		else $error("no capture after rising timer input");
	a_capture_cause: assert property (timer_ch2_a_capture
		|-> $past(timer_ch2_a_in) && !$past(timer_ch2_a_in, 2))
		else $error("capture without rising timer input");
	a_timer_excl: assert property (timer_ch2_a_in && $past(timer_ch2_a_in)
		|-> !port_in[6] && !pin_oe[6])
		else $error("timer input while port or output active");
endmodule
bind pin_function_select pin_function_select_assertions i_chk (.clk(clk), .rst(rst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_oe(pin_oe),
	.port_in(port_in), .timer_ch2_a_in(timer_ch2_a_in),
	.timer_ch2_a_capture(timer_ch2_a_capture));
`default_nettype wire

// *** pin_world.sv ***
// model: package pins with an outside driver on the undriven ones
`timescale 1ns/1ps
`default_nettype none
module pin_world (
	input wire logic [15:0] pin_out,
	input wire logic [15:0] pin_oe,
	input wire logic [15:0] ext_level,
	output logic [15:0] pin_in
);
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule
`default_nettype wire

// *** port_e_pin_function_select_tb.sv ***
// testbench: register, pin routing and capture checks for the pin function select block
`timescale 1ns/1ps
`default_nettype none
module port_e_pin_function_select_tb import pin_mux_pkg::*;;
	// ---------------------------------------------------------------
	// stimulus and model state
	// ---------------------------------------------------------------
	logic clk, rst, psel, penable, pwrite, pready, pslverr, tout, tin, cap, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [15:0] pin_in, pin_out, pin_oe, port_out, port_in, ext, seed;
	int fail_count, n_checks, cyc, pulses;
	int m[5];
	logic [7:0] offs[5] = '{OFF_MODE_3_0, OFF_MODE_7_4, OFF_MODE_11_8, OFF_MODE_15_12, OFF_DIRECTION};
	logic [15:0] msk[5] = '{MASK_MODE_3_0, MASK_MODE_7_4, MASK_MODE_11_8, MASK_MODE_15_12, 16'hFFFF};
	pin_function_select i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.port_out(port_out), .port_in(port_in), .timer_ch2_a_out(tout),
		.timer_ch2_a_in(tin), .timer_ch2_a_capture(cap));
	pin_world i_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));
	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		n_checks++;
		if (g !== x) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", n, x, g);
		end
	endtask
	// upper data bits are sent as ones so the dropped half is exercised
	task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'hFFFF, d};
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			summarize();
		end
	end
	initial begin
		{rst, psel, penable, pwrite, tout, paddr, pwdata, port_out, ext} = '0;
		rst = 1'h1;
		seed = 16'hEC90;
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		for (int i = 0; i < 5; i++) begin
			apb(1'h0, offs[i], 16'h0);
			chk("reset value", 32'h0, r);
		end
		apb(1'h1, 8'h18, 16'hFFFF);
		chk("unmapped error", 32'h1, {31'h0, e});
		for (int i = 0; i < 5; i++) begin
			seed = lfsr(seed);
			m[i] = seed & msk[i];
			apb(1'h1, offs[i], seed);
			apb(1'h0, offs[i], 16'h0);
			chk("register readback", m[i], r);
		end
		for (int i = 0; i < 4; i++) apb(1'h1, offs[i], 16'h0);
		seed = lfsr(seed);
		port_out <= seed;
		seed = lfsr(seed);
		ext <= seed;
		repeat (6) @(posedge clk);
		chk("pin enable", m[4], pin_oe);
		chk("pin drive", port_out, pin_out);
		chk("port level", (port_out & m[4]) | (ext & ~m[4]), port_in);
		apb(1'h0, OFF_PIN_LEVEL, 16'h0);
		chk("pin level read", (port_out & m[4]) | (ext & ~m[4]), r);
		chk("pin level error", 32'h0, {31'h0, e});
		apb(1'h1, OFF_MODE_7_4, {5'h0, MODE_TIMER_CH2_A, 8'h0});
		apb(1'h1, OFF_DIRECTION, 16'h0);
		ext <= 16'h0;
		repeat (6) @(posedge clk);
		ext <= 16'h0040;
		pulses = 0;
		repeat (8) begin
			@(posedge clk);
			pulses += (cap === 1'h1);
		end
		chk("capture pulses", 32'h1, pulses);
		chk("timer input", 32'h1, tin);
		chk("port bit six", 32'h0, port_in[6]);
		apb(1'h1, OFF_DIRECTION, 16'h0040);
		tout <= 1'h1;
		repeat (4) @(posedge clk);
		chk("timer drive", 32'h1, pin_out[6]);
		chk("timer input off", 32'h0, tin);
		summarize();
	end
endmodule
`default_nettype wire
